// >>> hdl/arpwm_pkg.sv
package arpwm_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  // ==========================================================================
  localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_COUNTER     = 4'h4;
  localparam logic [3:0] ADDR_RELOAD      = 4'h8;
  localparam logic [3:0] ADDR_PWM_CTRL    = 4'hc;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h0 + 4'h0;
  localparam logic [5:0] ADDR_IRQ_STAT    = 6'h10;
  localparam logic [5:0] ADDR_IRQ_CLEAR   = 6'h14;
  localparam logic [5:0] ADDR_IRQ_ENABLE  = 6'h18;
  localparam int         ADDR_W           = 6;

  // ==========================================================================
  // Control/status field positions
  // ==========================================================================
  localparam int BIT_EXT_CLK    = 7;
  localparam int BIT_DIV_HI     = 6;
  localparam int BIT_DIV_LO     = 4;
  localparam int BIT_COUNT_RUN  = 3;
  localparam int BIT_FORCE_RLD  = 2;
  localparam int BIT_OVF_IE     = 1;
  localparam int BIT_OVF_FLAG   = 0;

  // ==========================================================================
  // Sizes and reset values
  // ==========================================================================
  localparam int         PWM_CH       = 4;
  localparam int         PRESC_W      = 7;
  localparam logic [7:0] CNT_TOP      = 8'hff;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;
  localparam int         IRQ_W        = 2;
  localparam int         IRQ_OVF      = 0;
  localparam int         IRQ_FRELOAD  = 1;

  typedef struct packed {
    logic       ext_clock_select;
    logic [2:0] clock_divide_code;
    logic       count_run;
    logic       overflow_irq_enable;
  } arpwm_ctrl_s;

  typedef enum logic [1:0] {
    ARPWM_B_IDLE,
    ARPWM_B_RESP
  } arpwm_bstate_e;

endpackage : arpwm_pkg

// >>> hdl/arpwm_timer.sv
// ============================================================================
// ============================================================================
`timescale 1ns/100ps
`default_nettype none

module arpwm_timer (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [5:0]           s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // AXI4-Lite write response
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output var  logic [1:0]           s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  input  wire logic [5:0]           s_axi_araddr,
  // AXI4-Lite read data
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  // External count clock, sampled as a level
  input  wire logic                 ext_count_clk,
  // PWM outputs and interrupt
  output var  logic [3:0]           pwm_out,
  output var  logic                 irq
);
  import arpwm_pkg::*;

  // ==========================================================================
  // Register state
  // ==========================================================================
  arpwm_ctrl_s               ctrl_r;
  logic                      ovf_flag_r;
  logic [7:0]                counter_r;
  logic [7:0]                reload_r;
  logic [PWM_CH-1:0]         polarity_r;
  logic [PRESC_W-1:0]        presc_r;
  logic                      ext_prev_r;
  logic [IRQ_W-1:0]          irq_stat_r;
  logic [IRQ_W-1:0]          irq_en_r;

  // ==========================================================================
  // AXI4-Lite write channel: address and data may arrive in either order
  // ==========================================================================
  logic                      aw_hold_r;
  logic                      w_hold_r;
  logic [5:0]                awaddr_r;
  logic [31:0]               wdata_r;
  logic [3:0]                wstrb_r;

  wire aw_take   = s_axi_awvalid && s_axi_awready;
  wire w_take    = s_axi_wvalid && s_axi_wready;
  wire have_aw   = aw_hold_r || aw_take;
  wire have_w    = w_hold_r || w_take;
  // One write is open at most: a new one waits until its response is taken.
  wire wr_fire   = have_aw && have_w && !s_axi_bvalid;
  wire [5:0]  wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_r ? wdata_r : s_axi_wdata;
  wire        wr_lane0 = w_hold_r ? wstrb_r[0] : s_axi_wstrb[0];
  wire        wr_en   = wr_fire && wr_lane0;

  wire wr_csr    = wr_en && (wr_addr == {2'b00, ADDR_CTRL_STATUS});
  wire wr_cnt    = wr_en && (wr_addr == {2'b00, ADDR_COUNTER});
  wire wr_rld    = wr_en && (wr_addr == {2'b00, ADDR_RELOAD});
  wire wr_pwm    = wr_en && (wr_addr == {2'b00, ADDR_PWM_CTRL});
  wire wr_iclr   = wr_en && (wr_addr == ADDR_IRQ_CLEAR);
  wire wr_ien    = wr_en && (wr_addr == ADDR_IRQ_ENABLE);

  function automatic logic addr_mapped(input logic [5:0] a);
    addr_mapped = (a == {2'b00, ADDR_CTRL_STATUS}) || (a == {2'b00, ADDR_COUNTER}) ||
                  (a == {2'b00, ADDR_RELOAD}) || (a == {2'b00, ADDR_PWM_CTRL}) ||
                  (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_CLEAR) || (a == ADDR_IRQ_ENABLE);
  endfunction : addr_mapped

  wire force_reload = wr_csr && wr_data[BIT_FORCE_RLD];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 6'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !have_aw || wr_fire ? !wr_fire && !aw_take : 1'b0;
      s_axi_wready  <= !have_w || wr_fire ? !wr_fire && !w_take : 1'b0;
      if (aw_take && !wr_fire) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (w_take && !wr_fire) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_csr  = rd_take && (s_axi_araddr == {2'b00, ADDR_CTRL_STATUS});

  // Force-reload always reads as zero.
  wire [7:0] csr_view = {ctrl_r.ext_clock_select, ctrl_r.clock_divide_code,
                         ctrl_r.count_run, 1'b0, ctrl_r.overflow_irq_enable,
                         ovf_flag_r};
  wire [7:0] rd_byte =
    (s_axi_araddr == {2'b00, ADDR_CTRL_STATUS}) ? csr_view :
    (s_axi_araddr == {2'b00, ADDR_COUNTER})     ? counter_r :
    (s_axi_araddr == {2'b00, ADDR_RELOAD})      ? reload_r :
    (s_axi_araddr == {2'b00, ADDR_PWM_CTRL})    ? {4'h0, polarity_r} :
    (s_axi_araddr == ADDR_IRQ_STAT)             ? {6'h00, irq_stat_r} :
    (s_axi_araddr == ADDR_IRQ_ENABLE)           ? {6'h00, irq_en_r} : RST_BYTE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Prescaler and counter
  // ==========================================================================
  // The external clock is taken as a synchronous level; one rising edge
  // of it is one input tick, so it must stay at or below half the bus clock.
  wire       ext_rise = ext_count_clk && !ext_prev_r;
  wire       in_tick  = ctrl_r.ext_clock_select ? ext_rise : 1'b1;
  wire       running  = ctrl_r.count_run;
  wire [PRESC_W-1:0] presc_mask = PRESC_W'((8'h01 << ctrl_r.clock_divide_code) - 8'h01);
  wire       cnt_tick = running && in_tick && ((presc_r & presc_mask) == presc_mask);
  wire       overflow = cnt_tick && (counter_r == CNT_TOP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_r <= 1'b0;
      presc_r    <= '0;
      counter_r  <= RST_BYTE;
    end else begin
      ext_prev_r <= ext_count_clk;
      // A force reload wins over a tick; an overflow in that cycle is still
      // flagged, so software can tell that a period ended before the reload.
      if (force_reload) begin
        presc_r   <= '0;
        counter_r <= reload_r;
      end else begin
        if (running && in_tick) begin
          presc_r <= cnt_tick ? '0 : presc_r + 1'b1;
        end
        if (wr_cnt) begin
          counter_r <= wr_data[7:0];
        end else if (overflow) begin
          counter_r <= reload_r;
        end else if (cnt_tick) begin
          counter_r <= counter_r + 8'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Control registers, overflow flag, PWM levels, interrupt
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= '0;
      reload_r   <= RST_BYTE;
      polarity_r <= '0;
      ovf_flag_r <= 1'b0;
      pwm_out    <= '0;
      irq_stat_r <= '0;
      irq_en_r   <= '0;
      irq        <= 1'b0;
    end else begin
      if (wr_csr) begin
        ctrl_r.ext_clock_select    <= wr_data[BIT_EXT_CLK];
        ctrl_r.clock_divide_code   <= wr_data[BIT_DIV_HI:BIT_DIV_LO];
        ctrl_r.count_run           <= wr_data[BIT_COUNT_RUN];
        ctrl_r.overflow_irq_enable <= wr_data[BIT_OVF_IE];
      end
      if (wr_rld) begin
        reload_r <= wr_data[7:0];
      end
      if (wr_pwm) begin
        polarity_r <= wr_data[PWM_CH-1:0];
      end
      // Set wins over the read-clear so that no overflow is lost.
      if (overflow) begin
        ovf_flag_r <= 1'b1;
      end else if (rd_csr) begin
        ovf_flag_r <= 1'b0;
      end
      if (overflow) begin
        pwm_out <= polarity_r;
      end
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_OVF && overflow) || (i == IRQ_FRELOAD && force_reload)) begin
          irq_stat_r[i] <= 1'b1;
        end else if (wr_iclr && wr_data[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
      if (wr_ien) begin
        irq_en_r <= wr_data[IRQ_W-1:0];
      end
      irq <= (ctrl_r.overflow_irq_enable && ovf_flag_r) || |(irq_stat_r & irq_en_r);
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_ovf_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow |=> ovf_flag_r)
    else $error("overflow did not set flag");

  chk_ovf_reloads: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow && !force_reload && !wr_cnt |=> counter_r == $past(reload_r))
    else $error("overflow did not reload counter");

  chk_frz_when_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !running && !force_reload && !wr_cnt |=> $stable(counter_r) && $stable(presc_r))
    else $error("counter moved while stopped");

  chk_force_load: assert property (@(posedge aclk) disable iff (!aresetn)
    force_reload |=> counter_r == $past(reload_r) && presc_r == '0)
    else $error("force reload failed");

  chk_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_csr && !overflow |=> !ovf_flag_r)
    else $error("read did not clear flag");

  chk_fr_reads_0: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(rd_csr) |-> !s_axi_rdata[BIT_FORCE_RLD])
    else $error("force reload bit read as one");

  chk_pwm_level: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow |=> pwm_out == $past(polarity_r))
    else $error("pwm level not updated");

  chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf_flag_r && ctrl_r.overflow_irq_enable |=> irq)
    else $error("overflow interrupt missing");

  chk_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_tick && !overflow && !force_reload && !wr_cnt |=> counter_r == $past(counter_r) + 8'h01)
    else $error("counter did not step");

  // The reset check runs without the disable so that it sees reset itself.
  chk_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> counter_r == RST_BYTE && reload_r == RST_BYTE && ctrl_r == '0 && !ovf_flag_r)
    else $error("registers not cleared by reset");

  chk_ext_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r.ext_clock_select && !ext_rise && !force_reload && !wr_cnt |=>
      $stable(presc_r) && $stable(counter_r))
    else $error("count moved without external edge");

  chk_presc_step: assert property (@(posedge aclk) disable iff (!aresetn)
    running && in_tick && !cnt_tick && !force_reload |=> presc_r == $past(presc_r) + 7'h01)
    else $error("prescaler did not step");

  chk_irq_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_r.overflow_irq_enable && irq_en_r == '0 |=> !irq)
    else $error("interrupt raised while disabled");

  chk_flag_only_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    !ovf_flag_r && !overflow |=> !ovf_flag_r)
    else $error("flag set without overflow");

  chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf_flag_r && !rd_csr |=> ovf_flag_r)
    else $error("flag cleared without read");

  chk_cnt_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cnt |=> counter_r == $past(wr_data[7:0]))
    else $error("counter write lost");

  chk_pwm_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    !overflow |=> $stable(pwm_out))
    else $error("pwm level changed without overflow");

  chk_reload_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_rld |=> reload_r == $past(wr_data[7:0]))
    else $error("reload write lost");

  chk_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !cnt_tick && !force_reload && !wr_cnt |=> $stable(counter_r))
    else $error("counter moved without tick");

endmodule : arpwm_timer

`default_nettype wire

// >>> tb/arpwm_ext_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// External count clock source
// ============================================================================
module arpwm_ext_model (
  // Clock
  input  wire logic aclk,
  // Count clock pin
  output var  logic ext_count_clk
);
  // The pin rests low between bursts, so no stray edge reaches the prescaler.
  initial ext_count_clk = 1'b0;

  task automatic send_edges(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge aclk);
      ext_count_clk <= 1'b1;
      repeat (gap) @(posedge aclk);
      ext_count_clk <= 1'b0;
    end
  endtask : send_edges
endmodule : arpwm_ext_model
`default_nettype wire

// >>> tb/test_autoreload_pwm_timer_core.sv
`timescale 1ns/100ps
`default_nettype none
module test_autoreload_pwm_timer_core;
  import arpwm_pkg::*;
  localparam logic [5:0] A_CS = 6'(ADDR_CTRL_STATUS);
  localparam logic [5:0] A_CN = 6'(ADDR_COUNTER);
  localparam logic [5:0] A_RL = 6'(ADDR_RELOAD);
  localparam logic [5:0] A_PW = 6'(ADDR_PWM_CTRL);
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ext_clk, irq;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [1:0]  bresp, rresp;
  logic [3:0]  pwm, pv, wstrb;
  logic [7:0]  rv;
  logic [9:0]  expq[$];
  logic [9:0]  e;
  int          bad_count, samples_checked, cycles;

  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  arpwm_timer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .ext_count_clk(ext_clk), .pwm_out(pwm), .irq(irq));
  arpwm_ext_model u_ext (.aclk(aclk), .ext_count_clk(ext_clk));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    expq.push_back({r, 8'h00});
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    expq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // ==========================================================================
  // Response monitor and hang guard
  // ==========================================================================
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 10000) begin
      bad_count++;
      results();
    end
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = expq.pop_front();
      samples_checked++;
      if (bvalid && bresp !== e[9:8]) begin
        bad_count++;
        $display("mismatch bresp expected %h seen %h", e[9:8], bresp);
      end
      if (rvalid && {rresp, rdata} !== {e[9:8], 24'h0, e[7:0]}) begin
        bad_count++;
        $display("mismatch rdata expected %h seen %h", e, {rresp, rdata});
      end
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    seed = 32'd87912;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("pwm_out", 8'h00, {4'h0, pwm});
    chk("irq", 8'h00, {7'h0, irq});
    for (int a = 0; a < 28; a += 4) begin
      if (a != 20) rd(6'(a), 8'h00, RESP_OKAY);
    end
    rd(6'h1c, 8'h00, RESP_SLVERR);
    wr(6'h20, 8'h5a, RESP_SLVERR);
    $display("test reset done");
    seed = xs(seed);
    rv = seed[7:0];
    wr(A_RL, rv, RESP_OKAY);
    wr(A_CN, 8'h55, RESP_OKAY);
    wr(A_CS, 8'h04, RESP_OKAY);
    rd(A_CS, 8'h00, RESP_OKAY);
    rd(A_CN, rv, RESP_OKAY);
    // A write with byte lane 0 off must leave the register alone.
    wstrb <= 4'h0;
    wr(A_RL, ~rv, RESP_OKAY);
    wstrb <= 4'hf;
    rd(A_RL, rv, RESP_OKAY);
    $display("test force reload done");
    wr(A_RL, 8'h00, RESP_OKAY);
    // Each code gets exactly three counter ticks, then edges while frozen.
    for (int c = 0; c < 8; c++) begin
      wr(A_CS, {1'b1, c[2:0], 4'b1100}, RESP_OKAY);
      rd(A_CS, {1'b1, c[2:0], 4'b1000}, RESP_OKAY);
      u_ext.send_edges(3 << c, 1 + (c % 2));
      repeat (4) @(posedge aclk);
      wr(A_CS, {1'b1, c[2:0], 4'b0000}, RESP_OKAY);
      u_ext.send_edges(2, 1);
      rd(A_CN, 8'h03, RESP_OKAY);
    end
    $display("test divide done");
    for (int ie = 1; ie >= 0; ie--) begin
      seed = xs(seed);
      rv = seed[7:0];
      pv = seed[11:8];
      wr(A_RL, rv, RESP_OKAY);
      wr(A_PW, {4'h0, pv}, RESP_OKAY);
      wr(A_CS, {6'b100010, ie[0], 1'b0}, RESP_OKAY);
      wr(A_CN, 8'hff, RESP_OKAY);
      u_ext.send_edges(1, 1);
      repeat (4) @(posedge aclk);
      chk("pwm_out", {4'h0, pv}, {4'h0, pwm});
      chk("irq", {7'h0, ie[0]}, {7'h0, irq});
      rd(A_CS, {6'b100010, ie[0], 1'b1}, RESP_OKAY);
      rd(A_CS, {6'b100010, ie[0], 1'b0}, RESP_OKAY);
      rd(A_CN, rv, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("irq", 8'h00, {7'h0, irq});
    end
    $display("test overflow done");
    // CPU clock at divide-by-128 from reload fe: ff from 128 cycles after the
    // force reload, overflow back to fe at 256, ff again at 384.
    wr(A_RL, 8'hfe, RESP_OKAY);
    wr(A_CS, 8'h7c, RESP_OKAY);
    rd(A_CN, 8'hfe, RESP_OKAY);
    repeat (140) @(posedge aclk);
    rd(A_CN, 8'hff, RESP_OKAY);
    repeat (120) @(posedge aclk);
    rd(A_CS, 8'h79, RESP_OKAY);
    rd(A_CN, 8'hfe, RESP_OKAY);
    $display("test cpu clock done");
    wr(A_CS, 8'h00, RESP_OKAY);
    rd(6'(ADDR_IRQ_STAT), 8'h03, RESP_OKAY);
    wr(6'(ADDR_IRQ_ENABLE), 8'h01, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq", 8'h01, {7'h0, irq});
    wr(6'(ADDR_IRQ_ENABLE), 8'h00, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq", 8'h00, {7'h0, irq});
    wr(6'(ADDR_IRQ_ENABLE), 8'h01, RESP_OKAY);
    wr(6'(ADDR_IRQ_CLEAR), 8'h01, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq", 8'h00, {7'h0, irq});
    rd(6'(ADDR_IRQ_STAT), 8'h02, RESP_OKAY);
    $display("test interrupt done");
    repeat (2) @(posedge aclk);
    results();
  end
endmodule : test_autoreload_pwm_timer_core
`default_nettype wire
